/* acr_ctrl.sv */
// Converter control top: AXI4-Lite registers, conversion sequencing and abort handling.
`timescale 1ns/1ps
`default_nettype none

module acr_ctrl
	import acr_pkg::*;
(
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [ACR_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [ACR_DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [ACR_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [ACR_DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic                  stop_mode,
	input  wire acr_core_rsp_s         core_rsp,
	output acr_core_req_s              core_req,
	output logic                       irq
);

	// Register map: each register is one byte in the low end of an aligned 32-bit word.
	// The status and control byte carries the completion flag, continuous select and channel.
	// The clock configuration byte carries 10-bit mode, asynchronous clock enable and spares.
	// The two result bytes are read-only; writes to them answer OKAY and change nothing.
	// The event status byte is sticky and cleared by writing ones; the mask byte gates irq.
	// The core status byte shows a running conversion, an armed read lock and core power.
	// Any other offset answers with a slave error and has no side effect.
	// Upper data bits read as zero and are ignored on writes.

	// The record below holds every flop of the block outside the result holder; outputs are read straight from it.
	// Pulses in it are cleared at the top of the next-state logic and set where they occur.
	// Whole control state of the block.
	typedef struct packed {
		acr_state_e              state;
		logic                    cont;
		logic [ACR_CH_W-1:0]     ch;
		logic                    conversion_complete_flag;
		logic [7:0]              clk_cfg;
		logic [ACR_IRQ_W-1:0]    irq_st;
		logic [ACR_IRQ_W-1:0]    irq_mk;
		logic                    irq;
		logic                    awready;
		logic                    wready;
		logic                    have_aw;
		logic                    have_w;
		logic [ACR_ADDR_W-1:0]   awaddr;
		logic [7:0]              wdata;
		logic                    wen;
		logic                    bvalid;
		logic [1:0]              bresp;
		logic                    arready;
		logic                    rvalid;
		logic [1:0]              rresp;
		logic [ACR_DATA_W-1:0]   rdata;
		acr_core_req_s           req;
	} acr_ctrl_s;

	acr_ctrl_s st_ff;
	acr_ctrl_s nxt_st;

	// Glue between the bus slave, the result holder and the sequencer.
	// The read strobes are combinational so the lock tracks the access in the cycle it is taken.
	// The holder's outputs are registered, so blocked and transfer pulses come a cycle after done.
	// That extra cycle is why the sequencer restarts from the idle state rather than from done.
	logic       rd_high;
	logic       rd_low;
	logic       core_done;
	logic [7:0] res_hi;
	logic [7:0] res_lo;
	logic       res_xfer;
	logic       res_blocked;
	logic       res_pend;

	// Read side effects happen on the address handshake, so each read counts once.
	assign rd_high = s_axi_arvalid && st_ff.arready && (s_axi_araddr == ACR_OFF_RES_HI);
	assign rd_low  = s_axi_arvalid && st_ff.arready && (s_axi_araddr == ACR_OFF_RES_LO);

	// A done from the core counts only while a conversion is really running.
	assign core_done = core_rsp.done && (st_ff.state == ACR_ST_CONV) && !st_ff.req.abort;

	// The holder keeps the two result bytes and the two-byte read lock.
	// It sees done only while a conversion really runs, so a late done from an aborted
	// conversion can never overwrite the bytes.
	// Mode follows the clock configuration byte directly; a mode change is itself an abort.

	acr_result_hold u_hold (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.done      (core_done),
		.result    (core_rsp.result),
		.mode10    (st_ff.clk_cfg[ACR_CLK_MODE10_BIT]),
		.rd_high   (rd_high),
		.rd_low    (rd_low),
		.high_byte (res_hi),
		.low_byte  (res_lo),
		.xfer      (res_xfer),
		.blocked   (res_blocked),
		.pending   (res_pend)
	);

	// Next-state logic for bus slave, registers, sequencer and interrupt.
	always_comb begin
		logic       aw_hs;
		logic       w_hs;
		logic       do_wr;
		logic       wr_sc;
		logic       wr_clk;
		logic       stop_abort;
		logic       any_abort;
		logic       start_now;
		logic [7:0] rbyte;
		logic       rmap;
		logic [ACR_IRQ_W-1:0] ev;

		aw_hs      = s_axi_awvalid && st_ff.awready;
		w_hs       = s_axi_wvalid && st_ff.wready;
		do_wr      = 1'b0;
		wr_sc      = 1'b0;
		wr_clk     = 1'b0;
		stop_abort = 1'b0;
		any_abort  = 1'b0;
		start_now  = 1'b0;
		rbyte      = 8'h00;
		rmap       = 1'b1;
		ev         = '0;

		nxt_st           = st_ff;
		nxt_st.req.start = 1'b0;
		nxt_st.req.abort = 1'b0;
		nxt_st.wen       = 1'b0;

		// Each ready drops after its handshake and comes back only once the response is taken.
		// That keeps one write in flight with no queue; the price is a gap between writes.
		// Only the low data byte and its strobe matter, since every register is one byte wide.
		// Write address and data are accepted in either order.
		if (aw_hs) begin
			nxt_st.have_aw = 1'b1;
			nxt_st.awready = 1'b0;
			nxt_st.awaddr  = s_axi_awaddr;
		end
		if (w_hs) begin
			nxt_st.have_w = 1'b1;
			nxt_st.wready = 1'b0;
			nxt_st.wdata  = s_axi_wdata[7:0];
			nxt_st.wen    = s_axi_wstrb[0];
		end

		// The store happens one cycle after the later half arrives, from the held copies, so the address
		// may lead the data; data taken before its address loses its one-cycle strobe copy and is not stored.
		// Perform the write once both halves are held, then answer.
		if (st_ff.have_aw && st_ff.have_w && !st_ff.bvalid) begin
			do_wr          = st_ff.wen;
			nxt_st.have_aw = 1'b0;
			nxt_st.have_w  = 1'b0;
			nxt_st.bvalid  = 1'b1;
			nxt_st.bresp   = ACR_RESP_OKAY;
			unique case (st_ff.awaddr)
				ACR_OFF_SC: begin
					wr_sc = do_wr;
				end
				ACR_OFF_CLK: begin
					wr_clk = do_wr;
				end
				ACR_OFF_IRQ_ST, ACR_OFF_IRQ_MK, ACR_OFF_RES_HI, ACR_OFF_RES_LO,
				ACR_OFF_CORE: begin
					nxt_st.bresp = ACR_RESP_OKAY;
				end
				default: begin
					nxt_st.bresp = ACR_RESP_SLVERR;
				end
			endcase
		end
		// Taking the response reopens both channels together for the next write.
		// A slave error leaves every register untouched.
		if (st_ff.bvalid && s_axi_bready) begin
			nxt_st.bvalid  = 1'b0;
			nxt_st.awready = 1'b1;
			nxt_st.wready  = 1'b1;
		end

		// A store with the low strobe clear still answers OKAY but leaves every register alone.
		// Writing the control byte also clears the completion flag further down.
		// Register stores.
		if (wr_sc) begin
			nxt_st.cont = st_ff.wdata[ACR_SC_CONT_BIT];
			nxt_st.ch   = st_ff.wdata[ACR_CH_W-1:0];
		end
		if (wr_clk) begin
			nxt_st.clk_cfg = st_ff.wdata;
		end
		if (do_wr && st_ff.awaddr == ACR_OFF_IRQ_MK) begin
			nxt_st.irq_mk = st_ff.wdata[ACR_IRQ_W-1:0];
		end

		// Three things abort a running conversion besides reset: a control write, a clock
		// write, and stop mode while the asynchronous clock is off.
		// The abort event bit is raised only when a conversion was actually running,
		// so software can tell a real abort from a harmless configuration write.
		// Reset needs no term here because it clears the whole record below.
		// Abort sources other than reset.
		stop_abort = stop_mode && !st_ff.clk_cfg[ACR_CLK_ACLK_BIT];
		any_abort  = wr_sc || wr_clk || stop_abort;

		// The sequencer has only two states; the analog core owns all conversion timing.
		// A start pulse always goes with power on in the same cycle, so the core never sees
		// a start while its references are off.
		// A control write that restarts carries both the abort and the start pulse at once;
		// the core must treat start as winning so that the new conversion runs.
		// Stop mode without the asynchronous clock also blocks any restart until it ends.
		// Sequencer: abort first, then a fresh start that overrides it or a restart after a result.
		if (st_ff.state == ACR_ST_CONV && any_abort) begin
			nxt_st.req.abort = 1'b1;
			ev[ACR_IRQ_ABRT_BIT] = 1'b1;
		end
		if (any_abort) begin
			nxt_st.state = ACR_ST_OFF;
		end else if (core_done) begin
			nxt_st.state = ACR_ST_OFF;
		end
		if (wr_sc && st_ff.wdata[ACR_CH_W-1:0] != ACR_CH_OFF && !stop_abort) begin
			start_now = 1'b1;
		end
		if (!any_abort && st_ff.state == ACR_ST_OFF && res_blocked) begin
			start_now = 1'b1;
		end
		if (!any_abort && st_ff.state == ACR_ST_OFF && res_xfer && st_ff.cont) begin
			start_now = 1'b1;
		end
		if (start_now) begin
			nxt_st.state     = ACR_ST_CONV;
			nxt_st.req.start = 1'b1;
		end
		// Power, mode and channel to the core follow the next state, so they change
		// together with the start pulse.
		nxt_st.req.power_en = (nxt_st.state == ACR_ST_CONV);
		nxt_st.req.mode10   = nxt_st.clk_cfg[ACR_CLK_MODE10_BIT];
		nxt_st.req.channel  = nxt_st.ch;

		// A fresh result is never hidden by an access that raced it in the same cycle.
		// Completion flag: a transfer sets it and beats a clearing access.
		if (wr_sc || rd_low) begin
			nxt_st.conversion_complete_flag = 1'b0;
		end
		if (res_xfer) begin
			nxt_st.conversion_complete_flag = 1'b1;
		end

		// Read data are taken from the address in the cycle it is accepted and then held,
		// so a result that lands while rvalid waits for rready does not change the answer.
		// The low-byte read releases the lock at the same edge that captures the byte.
		// Read path: answer one cycle after the address is taken.
		unique case (s_axi_araddr)
			ACR_OFF_SC: begin
				rbyte = {st_ff.conversion_complete_flag, 1'b0, st_ff.cont, st_ff.ch};
			end
			ACR_OFF_CLK: begin
				rbyte = st_ff.clk_cfg;
			end
			ACR_OFF_RES_HI: begin
				rbyte = res_hi;
			end
			ACR_OFF_RES_LO: begin
				rbyte = res_lo;
			end
			ACR_OFF_IRQ_ST: begin
				rbyte = {5'h00, st_ff.irq_st};
			end
			ACR_OFF_IRQ_MK: begin
				rbyte = {5'h00, st_ff.irq_mk};
			end
			ACR_OFF_CORE: begin
				rbyte = {5'h00, st_ff.req.power_en, res_pend, st_ff.state == ACR_ST_CONV};
			end
			default: begin
				// Unmapped reads return zero data with a slave error and no side effect.
				rmap = 1'b0;
			end
		endcase
		if (s_axi_arvalid && st_ff.arready) begin
			nxt_st.arready = 1'b0;
			nxt_st.rvalid  = 1'b1;
			nxt_st.rdata   = {24'h000000, rbyte};
			nxt_st.rresp   = rmap ? ACR_RESP_OKAY : ACR_RESP_SLVERR;
		end
		if (st_ff.rvalid && s_axi_rready) begin
			nxt_st.rvalid  = 1'b0;
			nxt_st.arready = 1'b1;
		end

		// The interrupt is the registered OR of the status bits gated by the mask, taken from the next values,
		// so it rises in the same cycle as the status bit that causes it.
		// Sticky events: write one to clear, a new event in the same cycle survives.
		ev[ACR_IRQ_DONE_BIT] = res_xfer;
		ev[ACR_IRQ_DISC_BIT] = res_blocked;
		if (do_wr && st_ff.awaddr == ACR_OFF_IRQ_ST) begin
			nxt_st.irq_st = st_ff.irq_st & ~st_ff.wdata[ACR_IRQ_W-1:0];
		end
		nxt_st.irq_st = nxt_st.irq_st | ev;
		nxt_st.irq    = |(nxt_st.irq_st & nxt_st.irq_mk);
	end

	// Reset also clears the result bytes in the holder, unlike a plain abort.
	// The request resets with the channel at its off code, matching the stored channel.
	// A reset is itself an abort: sequencer off and core unpowered.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '{
				state:   ACR_ST_OFF,
				ch:      ACR_CH_RESET,
				clk_cfg: ACR_CLK_RESET,
				awready: 1'b1,
				wready:  1'b1,
				arready: 1'b1,
				req:     '{channel: ACR_CH_RESET, default: 1'b0},
				default: '0
			};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// No output passes through logic after its flip-flop, so the core sees clean levels.
	// Every output is a flip-flop of the state record.
	assign s_axi_awready = st_ff.awready;
	assign s_axi_wready  = st_ff.wready;
	assign s_axi_bvalid  = st_ff.bvalid;
	assign s_axi_bresp   = st_ff.bresp;
	assign s_axi_arready = st_ff.arready;
	assign s_axi_rvalid  = st_ff.rvalid;
	assign s_axi_rresp   = st_ff.rresp;
	assign s_axi_rdata   = st_ff.rdata;
	assign core_req      = st_ff.req;
	assign irq           = st_ff.irq;

endmodule

`default_nettype wire

/* acr_pkg.sv */
// Constants, register map and carrier types of the converter result-transfer and abort control.
package acr_pkg;

	// Bus geometry.
	localparam int unsigned ACR_ADDR_W = 8;
	localparam int unsigned ACR_DATA_W = 32;

	// Register byte addresses.
	localparam logic [7:0] ACR_OFF_SC     = 8'h00;
	localparam logic [7:0] ACR_OFF_CLK    = 8'h04;
	localparam logic [7:0] ACR_OFF_RES_HI = 8'h08;
	localparam logic [7:0] ACR_OFF_RES_LO = 8'h0c;
	localparam logic [7:0] ACR_OFF_IRQ_ST = 8'h10;
	localparam logic [7:0] ACR_OFF_IRQ_MK = 8'h14;
	localparam logic [7:0] ACR_OFF_CORE   = 8'h18;

	// Status/control fields.
	localparam int unsigned ACR_SC_CONVERSION_COMPLETE_FLAG_BIT = 7;
	localparam int unsigned ACR_SC_CONT_BIT = 5;
	localparam int unsigned ACR_CH_W        = 5;
	localparam logic [4:0]  ACR_CH_OFF      = 5'h1f;
	localparam logic [4:0]  ACR_CH_RESET    = 5'h1f;

	// Clock configuration fields.
	localparam int unsigned ACR_CLK_MODE10_BIT = 0;
	localparam int unsigned ACR_CLK_ACLK_BIT   = 1;
	localparam int unsigned ACR_CLK_MISC_LSB   = 2;
	localparam int unsigned ACR_CLK_MISC_W     = 6;
	localparam logic [7:0]  ACR_CLK_RESET      = 8'h00;

	// Interrupt status and mask bits.
	localparam int unsigned ACR_IRQ_W        = 3;
	localparam int unsigned ACR_IRQ_DONE_BIT = 0;
	localparam int unsigned ACR_IRQ_DISC_BIT = 1;
	localparam int unsigned ACR_IRQ_ABRT_BIT = 2;

	// Core status fields.
	localparam int unsigned ACR_CS_BUSY_BIT = 0;
	localparam int unsigned ACR_CS_PEND_BIT = 1;
	localparam int unsigned ACR_CS_PWR_BIT  = 2;

	// Result widths and reset value.
	localparam int unsigned ACR_RES_W    = 10;
	localparam logic [7:0]  ACR_BYTE_RST = 8'h00;

	// Bus responses.
	localparam logic [1:0] ACR_RESP_OKAY   = 2'h0;
	localparam logic [1:0] ACR_RESP_SLVERR = 2'h2;

	// Conversion sequencer states, one-hot.
	typedef enum logic [1:0] {
		ACR_ST_OFF  = 2'h1,
		ACR_ST_CONV = 2'h2
	} acr_state_e;

	// Requests to the analog core.
	typedef struct packed {
		logic                start;
		logic                abort;
		logic                power_en;
		logic                mode10;
		logic [ACR_CH_W-1:0] channel;
	} acr_core_req_s;

	// Answers from the analog core.
	typedef struct packed {
		logic                 done;
		logic [ACR_RES_W-1:0] result;
	} acr_core_rsp_s;

endpackage

/* acr_result_hold.sv */
// Result byte pair with the two-byte read interlock.
`timescale 1ns/1ps
`default_nettype none

module acr_result_hold
	import acr_pkg::*;
(
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic                 done,
	input  wire logic [ACR_RES_W-1:0] result,
	input  wire logic                 mode10,
	input  wire logic                 rd_high,
	input  wire logic                 rd_low,
	output logic [7:0]                high_byte,
	output logic [7:0]                low_byte,
	output logic                      xfer,
	output logic                      blocked,
	output logic                      pending
);

	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
		logic       xfer;
		logic       blocked;
		logic       pend;
	} acr_hold_s;

	acr_hold_s st_ff;
	acr_hold_s nxt_st;

	// Transfer or discard a finished result, and track a half-read pair.
	always_comb begin
		nxt_st         = st_ff;
		nxt_st.xfer    = 1'b0;
		nxt_st.blocked = 1'b0;
		if (done) begin
			if (st_ff.pend && mode10) begin
				nxt_st.blocked = 1'b1;
			end else begin
				nxt_st.xfer = 1'b1;
				if (mode10) begin
					nxt_st.hi = {6'h00, result[9:8]};
					nxt_st.lo = result[7:0];
				end else begin
					nxt_st.hi = ACR_BYTE_RST;
					nxt_st.lo = result[9:2];
				end
			end
		end
		// A high read arms the lock only in 10-bit mode; the low read releases it.
		if (rd_high && mode10) begin
			nxt_st.pend = 1'b1;
		end
		if (rd_low) begin
			nxt_st.pend = 1'b0;
		end
	end

	// Only reset touches the bytes outside a transfer.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '{hi: ACR_BYTE_RST, lo: ACR_BYTE_RST, default: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign high_byte = st_ff.hi;
	assign low_byte  = st_ff.lo;
	assign xfer      = st_ff.xfer;
	assign blocked   = st_ff.blocked;
	assign pending   = st_ff.pend;

endmodule

`default_nettype wire

/* acr_monitor.sv */
// Port checker for the converter control top.
`timescale 1ns/1ps
`default_nettype none
module acr_monitor
	import acr_pkg::*;
(
	input wire logic          aclk,
	input wire logic          aresetn,
	input wire logic          s_axi_awvalid,
	input wire logic          s_axi_awready,
	input wire logic          s_axi_wvalid,
	input wire logic          s_axi_wready,
	input wire logic          s_axi_bvalid,
	input wire logic          s_axi_arvalid,
	input wire logic          s_axi_arready,
	input wire logic          s_axi_rvalid,
	input wire acr_core_req_s core_req,
	input wire logic          irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// A write counts once both halves are taken in one cycle.
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	AST_RST_IDLE: assert property (disable iff (1'b0) !aresetn |=> !core_req.power_en &&
		!core_req.start && core_req.channel == ACR_CH_RESET && !irq) else $error("reset state");
	AST_ABORT_OFF: assert property (core_req.abort |->
		(core_req.start && core_req.power_en) || (!core_req.start && !core_req.power_en))
		else $error("abort left core powered");
	AST_ABORT_PULSE: assert property (core_req.abort |=> !core_req.abort)
		else $error("abort not a pulse");
	AST_START_PULSE: assert property (core_req.start |=> !core_req.start)
		else $error("start not a pulse");
	AST_START_PWR: assert property (core_req.start |-> ##[0:1] core_req.power_en)
		else $error("start without power");
	AST_WR_RESP: assert property (wr_take |-> ##2 s_axi_bvalid)
		else $error("write response late");
	AST_AW_BUSY: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("address ready stayed high");
	AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	AST_AR_BUSY: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
		else $error("read ready stayed high");
endmodule
`default_nettype wire

/* acr_core_model.sv */
// Behavioural analog converter core with a fixed conversion time.
`timescale 1ns/1ps
`default_nettype none
module acr_core_model
	import acr_pkg::*;
#(
	parameter int DLY = 30
)
(
	input wire logic          aclk,
	input wire logic          aresetn,
	input wire acr_core_req_s core_req,
	input wire logic [9:0]    value,
	output acr_core_rsp_s     core_rsp
);
	logic busy;
	int   cnt;
	// A start always restarts the count, even with an abort beside it; a lone abort drops it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy <= 1'b0;
		end else if (core_req.start) begin
			busy <= 1'b1;
			cnt <= DLY;
		end else if (core_req.abort) begin
			busy <= 1'b0;
		end else if (busy) begin
			busy <= (cnt != 0);
			cnt <= cnt - 1;
		end
	end
	// Outside the done pulse the result lines carry junk, not the last value.
	assign core_rsp.done = busy && cnt == 0;
	assign core_rsp.result = core_rsp.done ? value : ~value;
endmodule
`default_nettype wire

/* acr_tb.sv */
// Self-checking bench for the converter control top.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import acr_pkg::*;
	logic          aclk = 1'b0;
	logic          aresetn = 1'b0;
	logic [7:0]    s_axi_awaddr = 8'h00;
	logic          s_axi_awvalid = 1'b0;
	logic          s_axi_awready;
	logic [31:0]   s_axi_wdata = 32'h0;
	logic          s_axi_wvalid = 1'b0;
	logic          s_axi_wready;
	logic [1:0]    s_axi_bresp;
	logic          s_axi_bvalid;
	logic          s_axi_bready = 1'b0;
	logic [7:0]    s_axi_araddr = 8'h00;
	logic          s_axi_arvalid = 1'b0;
	logic          s_axi_arready;
	logic [31:0]   s_axi_rdata;
	logic [1:0]    s_axi_rresp;
	logic          s_axi_rvalid;
	logic          s_axi_rready = 1'b0;
	logic          stop_mode = 1'b0;
	logic [9:0]    value = 10'h000;
	acr_core_rsp_s core_rsp;
	acr_core_req_s core_req;
	logic          irq;
	logic [31:0]   rd_d;
	logic [1:0]    rd_r;
	logic [1:0]    wr_r;
	int            mismatches = 0;
	int            checks_done = 0;
	acr_ctrl acr_ctrl_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stop_mode, .core_rsp,
		.core_req, .irq);
	acr_core_model acr_core_model_i (.aclk, .aresetn, .core_req, .value, .core_rsp);
	// Free-running 200 MHz clock.
	initial begin
		forever #2.5 aclk = ~aclk;
	end
	task automatic test_done();
		if (mismatches == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// A used-up bound means the design never answered.
	task automatic to(input int n);
		if (n >= 100) begin
			mismatches++;
			$display("mismatch at %0t: no answer", $time);
			test_done();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				wr_r = s_axi_bresp;
				break;
			end
		end
		s_axi_bready <= 1'b0;
		to(n);
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				rd_d = s_axi_rdata;
				rd_r = s_axi_rresp;
				break;
			end
		end
		s_axi_rready <= 1'b0;
		to(n);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a);
		chk(rd_d & m, e);
	endtask
	// Polls a register until a masked bit shows up.
	task automatic wt(input logic [7:0] a, input logic [31:0] m);
		int n;
		for (n = 0; n < 100; n++) begin
			rd(a);
			if ((rd_d & m) !== 32'h0) break;
		end
		to(n);
	endtask
	// Main sequence.
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rc(ACR_OFF_RES_HI, 32'hff, 32'h0);
		rc(ACR_OFF_RES_LO, 32'hff, 32'h0);
		wr(ACR_OFF_IRQ_MK, 32'h7);
		chk({30'h0, wr_r}, {30'h0, ACR_RESP_OKAY});
		wr(ACR_OFF_CLK, 32'h1);
		value <= 10'h2a5;
		wr(ACR_OFF_SC, 32'h0);
		wt(ACR_OFF_SC, 32'h80);
		rc(ACR_OFF_RES_HI, 32'hff, 32'h02);
		rc(ACR_OFF_RES_LO, 32'hff, 32'ha5);
		// High byte read mid-conversion: the result must be thrown away.
		value <= 10'h155;
		wr(ACR_OFF_SC, 32'h0);
		rc(ACR_OFF_RES_HI, 32'hff, 32'h02);
		wt(ACR_OFF_IRQ_ST, 32'h2);
		rc(ACR_OFF_SC, 32'hff, 32'h0);
		rc(ACR_OFF_CORE, 32'h1, 32'h1);
		rc(ACR_OFF_RES_LO, 32'hff, 32'ha5);
		wt(ACR_OFF_SC, 32'h80);
		rc(ACR_OFF_RES_HI, 32'hff, 32'h01);
		rc(ACR_OFF_RES_LO, 32'hff, 32'h55);
		// Clock write aborts; bytes and power must follow.
		wr(ACR_OFF_IRQ_ST, 32'h7);
		value <= 10'h3ff;
		wr(ACR_OFF_SC, 32'h0);
		wr(ACR_OFF_CLK, 32'h1);
		rc(ACR_OFF_CORE, 32'h7, 32'h0);
		rc(ACR_OFF_IRQ_ST, 32'h7, 32'h4);
		chk({31'h0, irq}, 32'h1);
		wr(ACR_OFF_IRQ_ST, 32'h4);
		@(negedge aclk);
		chk({31'h0, irq}, 32'h0);
		rc(ACR_OFF_RES_HI, 32'hff, 32'h01);
		rc(ACR_OFF_RES_LO, 32'hff, 32'h55);
		// Channel all ones starts nothing; other control writes restart.
		wr(ACR_OFF_SC, 32'h1f);
		rc(ACR_OFF_CORE, 32'h7, 32'h0);
		wr(ACR_OFF_SC, 32'h3);
		wr(ACR_OFF_SC, 32'h3);
		chk({27'h0, core_req.channel}, 32'h3);
		chk({31'h0, core_req.mode10}, 32'h1);
		rc(ACR_OFF_IRQ_ST, 32'h7, 32'h4);
		rc(ACR_OFF_CORE, 32'h1, 32'h1);
		stop_mode <= 1'b1;
		rc(ACR_OFF_CORE, 32'h7, 32'h0);
		stop_mode <= 1'b0;
		rd(8'h1c);
		chk({30'h0, rd_r}, {30'h0, ACR_RESP_SLVERR});
		wr(8'h1c, 32'h0);
		chk({30'h0, wr_r}, {30'h0, ACR_RESP_SLVERR});
		// 8-bit mode: a high-byte read arms no lock, so the result still lands.
		wr(ACR_OFF_CLK, 32'h0);
		value <= 10'h2a5;
		wr(ACR_OFF_SC, 32'h0);
		chk({31'h0, core_req.mode10}, 32'h0);
		rc(ACR_OFF_RES_HI, 32'hff, 32'h01);
		rc(ACR_OFF_CORE, 32'h2, 32'h0);
		wt(ACR_OFF_SC, 32'h80);
		rc(ACR_OFF_RES_HI, 32'hff, 32'h00);
		rc(ACR_OFF_RES_LO, 32'hff, 32'ha9);
		// A reset clears the result bytes.
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rc(ACR_OFF_RES_HI, 32'hff, 32'h0);
		rc(ACR_OFF_RES_LO, 32'hff, 32'h0);
		test_done();
	end
endmodule
bind acr_ctrl acr_monitor acr_monitor_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .core_req, .irq);
`default_nettype wire
